// File: shared/decoder_clock_pkg.sv
package decoder_clock_pkg;

   // ==========================================================
   // Clock figures
   // ==========================================================
   localparam int unsigned XTAL_BASE_HZ = 8_467_200;
   localparam int unsigned XTAL_MULTIPLY = 8;
   localparam int unsigned MASTER_CLOCK_HZ = XTAL_BASE_HZ * XTAL_MULTIPLY;
   localparam int unsigned SYSTEM_CLOCK_DIVIDER_MAX_SEL = 4;

   // ==========================================================
   // Register byte addresses
   // ==========================================================
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_ANALOG_PLL_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_SYSTEM_CLOCK_CONFIG = 12'h004;
   localparam logic [11:0] ADDR_SERIAL_CLOCK_DIVIDER_CONFIG = 12'h008;
   localparam logic [11:0] ADDR_SPDIF_CLOCK_DIVIDER_CONFIG = 12'h00C;
   localparam logic [11:0] ADDR_SERIAL_AUDIO_CONFIG = 12'h010;
   localparam logic [11:0] ADDR_AUX_CLOCK_CONFIG = 12'h014;
   localparam logic [11:0] ADDR_LATCHED_IRQ_STATUS = 12'h018;
   localparam logic [11:0] ADDR_PASSTHROUGH_IRQ_STATUS = 12'h01C;
   localparam logic [11:0] ADDR_LATCHED_IRQ_MASK = 12'h020;
   localparam logic [11:0] ADDR_PASSTHROUGH_IRQ_MASK = 12'h024;
   localparam logic [11:0] ADDR_OWN_LAST = 12'h24C;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int PLL_HALVE_BIT = 0;
   localparam int SYSTEM_CLOCK_DIVIDER_LSB = 0;
   localparam int SYSTEM_CLOCK_DIVIDER_W = 3;
   localparam int SLEEP_BIT = 3;
   localparam int DIV_W = 7;
   localparam int GATE_BIT = 7;
   localparam int SLAVE_BIT = 0;
   localparam int RECEIVE_BIT = 1;
   localparam int AUX_W = 4;
   localparam int DEBUG_LSB = 0;
   localparam int DAC_LSB = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_SPDIF_DIV = 8'h0B;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic sel;
      logic write;
      logic [11:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] multiply;
      logic prediv_two;
   } pll_ctrl_t;

endpackage : decoder_clock_pkg

// File: design/clock_divider.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Divided clock, 50 % duty, period 2*(half+1) input cycles
// ==========================================================
module clock_divider #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Control
   input wire logic i_run,
   input wire logic [W-1:0] i_half,
   // Divided clock
   output logic o_clk
);

   logic [W-1:0] count;

   // Stopped divider parks low so restart gives a full first phase
   always_ff @(posedge i_clk) begin
      if (!i_rstn || !i_run) begin
         count <= '0;
         o_clk <= 1'b0;
      end else if (count >= i_half) begin
         count <= '0;
         o_clk <= ~o_clk;
      end else begin
         count <= count + 1'b1;
      end
   end

   property p_div_park;
      @(posedge i_clk) disable iff (!i_rstn) !i_run |=> !o_clk;
   endproperty
   a_div_park: assert property (p_div_park) else $error("divider output not parked");

endmodule : clock_divider

`default_nettype wire

// File: design/decoder_clock_irq_host.sv
// ==========================================================
// Behaviour
// - Master clock runs at eight times the base crystal frequency.
// - Double-frequency crystal is halved before multiplying; master rate unchanged.
// - System clock is master divided by two, 50 % duty, optionally further.
// - System clock division selectable among 2, 4, 8, 16 and 32.
// - System clock config powers down most decoder clocks for sleep.
// - Serial bit clock drives audio back end and leaves on the bit-clock pin.
// - Bit clock config selects division ratio and enables bit clock gating.
// - S/PDIF output enabled only while in audio slave mode.
// - RF sample clock equals master clock and captures converter samples.
// - Receive mode makes the back end use the incoming serial bit clock.
// - Debug monitor and external DAC clocks programmable via aux config.
// - Registers hold 8 bits in a 32-bit word; upper 24 read zero.
// - Own registers span base to own range end; higher range not here.
// - Latched status bits set by events, cleared by reading that register.
// - Pass-through status bits follow their hardware conditions.
// - Every status bit has its own writable enable bit.
// - Active-low interrupt when any enabled status bit is set.
// - Disabled status bits still set and readable for polling.
// ==========================================================
`timescale 1ns/1ps
`default_nettype none

module decoder_clock_irq_host #(
   parameter int IRQ_W = 8
) (
   // Clock and reset (i_clk stands for the master clock)
   input wire logic i_clk,
   input wire logic i_rstn,
   // Register access port
   input wire decoder_clock_pkg::reg_req_t i_reg,
   output logic [31:0] o_reg_rdata,
   // Interrupt sources and line
   input wire logic [IRQ_W-1:0] i_latched_events,
   input wire logic [IRQ_W-1:0] i_passthrough_conditions,
   output logic o_irq_n,
   // Analog clock multiplier control
   output decoder_clock_pkg::pll_ctrl_t o_pll_ctrl,
   // Generated clocks
   output logic o_rf_sample_clock,
   output logic o_system_clock,
   output logic o_spdif_clock,
   output logic o_spdif_enable,
   output logic o_debug_monitor_clock,
   output logic o_external_dac_clock,
   // Serial audio bit clock
   input wire logic i_bitclk_demand,
   input wire logic i_bitclk_pin,
   output logic o_bitclk_pin,
   output logic o_bitclk_pin_oe,
   output logic o_backend_bitclk
);

   // ==========================================================
   // Configuration registers
   // ==========================================================
   logic [7:0] analog_pll_control;
   logic [7:0] system_clock_config;
   logic [7:0] serial_clock_divider_config;
   logic [7:0] spdif_clock_divider_config;
   logic [7:0] serial_audio_config;
   logic [7:0] aux_clock_config;
   logic [IRQ_W-1:0] latched_irq_status;
   logic [IRQ_W-1:0] passthrough_irq_status;
   logic [IRQ_W-1:0] latched_irq_mask;
   logic [IRQ_W-1:0] passthrough_irq_mask;

   logic wr, rd, sleep, audio_slave, receive_bitclk;
   logic gate_enable, bitclk_run, bitclk_gen, pin_meta, pin_sync;
   logic [2:0] system_clock_divider_sel;
   logic [4:0] sys_half;
   logic [IRQ_W-1:0] next_latched;

   // ==========================================================
   // Helpers
   // ==========================================================
   // Clamp divider select so illegal codes fall back to divide by 32
   function automatic logic [4:0] sys_half_of(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > 3'(decoder_clock_pkg::SYSTEM_CLOCK_DIVIDER_MAX_SEL)) ? 3'(decoder_clock_pkg::SYSTEM_CLOCK_DIVIDER_MAX_SEL) : sel;
      sys_half_of = 5'((6'h01 << s) - 6'h01);
   endfunction : sys_half_of

   // Pads a byte register into one bus word
   function automatic logic [31:0] word_of(input logic [7:0] b);
      word_of = {24'h0000_00, b};
   endfunction : word_of

   assign wr = i_reg.sel & i_reg.write;
   assign rd = i_reg.sel & ~i_reg.write;

   // ==========================================================
   // Register writes
   // ==========================================================
   // Only listed own addresses store; anything else is dropped
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         analog_pll_control <= decoder_clock_pkg::RESET_BYTE;
         system_clock_config <= decoder_clock_pkg::RESET_BYTE;
         serial_clock_divider_config <= decoder_clock_pkg::RESET_BYTE;
         spdif_clock_divider_config <= decoder_clock_pkg::RESET_SPDIF_DIV;
         serial_audio_config <= decoder_clock_pkg::RESET_BYTE;
         aux_clock_config <= decoder_clock_pkg::RESET_BYTE;
         latched_irq_mask <= '0;
         passthrough_irq_mask <= '0;
      end else if (wr) begin
         unique case (i_reg.addr)
            decoder_clock_pkg::ADDR_ANALOG_PLL_CONTROL: analog_pll_control <= i_reg.wdata;
            decoder_clock_pkg::ADDR_SYSTEM_CLOCK_CONFIG: system_clock_config <= i_reg.wdata;
            decoder_clock_pkg::ADDR_SERIAL_CLOCK_DIVIDER_CONFIG: serial_clock_divider_config <= i_reg.wdata;
            decoder_clock_pkg::ADDR_SPDIF_CLOCK_DIVIDER_CONFIG: spdif_clock_divider_config <= i_reg.wdata;
            decoder_clock_pkg::ADDR_SERIAL_AUDIO_CONFIG: serial_audio_config <= i_reg.wdata;
            decoder_clock_pkg::ADDR_AUX_CLOCK_CONFIG: aux_clock_config <= i_reg.wdata;
            decoder_clock_pkg::ADDR_LATCHED_IRQ_MASK: latched_irq_mask <= i_reg.wdata[IRQ_W-1:0];
            decoder_clock_pkg::ADDR_PASSTHROUGH_IRQ_MASK: passthrough_irq_mask <= i_reg.wdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Register reads
   // ==========================================================
   // Registered read data, valid the cycle after the read strobe
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_reg_rdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (i_reg.addr)
            decoder_clock_pkg::ADDR_ANALOG_PLL_CONTROL: o_reg_rdata <= word_of(analog_pll_control);
            decoder_clock_pkg::ADDR_SYSTEM_CLOCK_CONFIG: o_reg_rdata <= word_of(system_clock_config);
            decoder_clock_pkg::ADDR_SERIAL_CLOCK_DIVIDER_CONFIG: o_reg_rdata <= word_of(serial_clock_divider_config);
            decoder_clock_pkg::ADDR_SPDIF_CLOCK_DIVIDER_CONFIG: o_reg_rdata <= word_of(spdif_clock_divider_config);
            decoder_clock_pkg::ADDR_SERIAL_AUDIO_CONFIG: o_reg_rdata <= word_of(serial_audio_config);
            decoder_clock_pkg::ADDR_AUX_CLOCK_CONFIG: o_reg_rdata <= word_of(aux_clock_config);
            decoder_clock_pkg::ADDR_LATCHED_IRQ_STATUS: o_reg_rdata <= word_of(8'(latched_irq_status));
            decoder_clock_pkg::ADDR_PASSTHROUGH_IRQ_STATUS: o_reg_rdata <= word_of(8'(passthrough_irq_status));
            decoder_clock_pkg::ADDR_LATCHED_IRQ_MASK: o_reg_rdata <= word_of(8'(latched_irq_mask));
            decoder_clock_pkg::ADDR_PASSTHROUGH_IRQ_MASK: o_reg_rdata <= word_of(8'(passthrough_irq_mask));
            default: o_reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Interrupt status
   // ==========================================================
   // Set wins over the read-clear, so an event on the read edge survives
   always_comb begin
      next_latched = latched_irq_status;
      if (rd && i_reg.addr == decoder_clock_pkg::ADDR_LATCHED_IRQ_STATUS) begin
         next_latched = '0;
      end
      next_latched = next_latched | i_latched_events;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         latched_irq_status <= '0;
      end else begin
         latched_irq_status <= next_latched;
      end
   end

   // Feed-through bits copy their condition; clearing is the source's job
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         passthrough_irq_status <= '0;
      end else begin
         passthrough_irq_status <= i_passthrough_conditions;
      end
   end

   // Active-low line, registered to keep it glitch free
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_irq_n <= 1'b1;
      end else begin
         o_irq_n <= ~(|(latched_irq_status & latched_irq_mask) |
                      |(passthrough_irq_status & passthrough_irq_mask));
      end
   end

   // ==========================================================
   // Clock controls
   // ==========================================================
   assign sleep = system_clock_config[decoder_clock_pkg::SLEEP_BIT];
   assign audio_slave = serial_audio_config[decoder_clock_pkg::SLAVE_BIT];
   assign receive_bitclk = serial_audio_config[decoder_clock_pkg::RECEIVE_BIT];
   assign gate_enable = serial_clock_divider_config[decoder_clock_pkg::GATE_BIT];
   assign system_clock_divider_sel = system_clock_config[decoder_clock_pkg::SYSTEM_CLOCK_DIVIDER_LSB +: decoder_clock_pkg::SYSTEM_CLOCK_DIVIDER_W];
   assign sys_half = sys_half_of(system_clock_divider_sel);

   // Multiplier is fixed; only the crystal predivider follows software
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pll_ctrl <= '{multiply: 4'(decoder_clock_pkg::XTAL_MULTIPLY), prediv_two: 1'b0};
      end else begin
         o_pll_ctrl.multiply <= 4'(decoder_clock_pkg::XTAL_MULTIPLY);
         o_pll_ctrl.prediv_two <= analog_pll_control[decoder_clock_pkg::PLL_HALVE_BIT];
      end
   end

   // Converter capture clock is the master clock itself, never gated
   assign o_rf_sample_clock = i_clk;

   // Gated mode runs the bit clock only while the back end asks for bits
   assign bitclk_run = !receive_bitclk && (!gate_enable || i_bitclk_demand);

   // Incoming bit clock pin passes two flops before use
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= i_bitclk_pin;
         pin_sync <= pin_meta;
      end
   end

   // Back end clock source and pin direction
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_backend_bitclk <= 1'b0;
         o_bitclk_pin <= 1'b0;
         o_bitclk_pin_oe <= 1'b0;
      end else begin
         o_backend_bitclk <= receive_bitclk ? pin_sync : bitclk_gen;
         o_bitclk_pin <= bitclk_gen;
         o_bitclk_pin_oe <= ~receive_bitclk;
      end
   end

   // S/PDIF only in audio slave mode; sleep also stops it
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_spdif_enable <= 1'b0;
      end else begin
         o_spdif_enable <= audio_slave & ~sleep;
      end
   end

   // ==========================================================
   // Dividers
   // ==========================================================
   // Sleep stops every divider; the converter capture clock and, in receive mode, the back end bit clock from the pin keep running
   clock_divider #(.W(5)) u_sys_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_run(~sleep),
      .i_half(sys_half),
      .o_clk(o_system_clock)
   );
   clock_divider #(.W(decoder_clock_pkg::DIV_W)) u_bit_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_run(bitclk_run & ~sleep),
      .i_half(serial_clock_divider_config[decoder_clock_pkg::DIV_W-1:0]),
      .o_clk(bitclk_gen)
   );
   clock_divider #(.W(8)) u_spdif_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_run(audio_slave & ~sleep),
      .i_half(spdif_clock_divider_config),
      .o_clk(o_spdif_clock)
   );
   clock_divider #(.W(decoder_clock_pkg::AUX_W)) u_debug_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_run(~sleep),
      .i_half(aux_clock_config[decoder_clock_pkg::DEBUG_LSB +: decoder_clock_pkg::AUX_W]),
      .o_clk(o_debug_monitor_clock)
   );
   clock_divider #(.W(decoder_clock_pkg::AUX_W)) u_dac_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_run(~sleep),
      .i_half(aux_clock_config[decoder_clock_pkg::DAC_LSB +: decoder_clock_pkg::AUX_W]),
      .o_clk(o_external_dac_clock)
   );

   // ==========================================================
   // Assertions
   // ==========================================================
   sequence s_read_latched;
      rd && i_reg.addr == decoder_clock_pkg::ADDR_LATCHED_IRQ_STATUS;
   endsequence

   property p_read_clears;
      @(posedge i_clk) disable iff (!i_rstn)
         s_read_latched ##0 (i_latched_events == '0) |=> latched_irq_status == '0;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("latched status not cleared by read");
   property p_set_wins;
      @(posedge i_clk) disable iff (!i_rstn)
         s_read_latched ##0 (i_latched_events != '0) |=> latched_irq_status == $past(i_latched_events);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on read edge");
   property p_latched_sticky;
      @(posedge i_clk) disable iff (!i_rstn)
         !rd |=> (latched_irq_status & $past(latched_irq_status)) == $past(latched_irq_status);
   endproperty
   a_latched_sticky: assert property (p_latched_sticky) else $error("latched bit dropped without read");
   property p_pass_follow;
      @(posedge i_clk) disable iff (!i_rstn)
         1'b1 |=> passthrough_irq_status == $past(i_passthrough_conditions);
   endproperty
   a_pass_follow: assert property (p_pass_follow) else $error("pass-through bit not following");
   property p_irq_line;
      @(posedge i_clk) disable iff (!i_rstn)
         1'b1 |=> o_irq_n == !(|($past(latched_irq_status) & $past(latched_irq_mask)) ||
                               |($past(passthrough_irq_status) & $past(passthrough_irq_mask)));
   endproperty
   a_irq_line: assert property (p_irq_line) else $error("interrupt line wrong");
   property p_upper_zero;
      @(posedge i_clk) disable iff (!i_rstn) o_reg_rdata[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
   property p_unmapped_zero;
      @(posedge i_clk) disable iff (!i_rstn)
         rd && i_reg.addr > decoder_clock_pkg::ADDR_PASSTHROUGH_IRQ_MASK |=> o_reg_rdata == 32'h0000_0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_spdif_slave;
      @(posedge i_clk) disable iff (!i_rstn) o_spdif_enable |-> $past(audio_slave);
   endproperty
   a_spdif_slave: assert property (p_spdif_slave) else $error("spdif enabled outside slave mode");
   property p_receive_pin;
      @(posedge i_clk) disable iff (!i_rstn)
         receive_bitclk |=> !o_bitclk_pin_oe && o_backend_bitclk == $past(pin_sync);
   endproperty
   a_receive_pin: assert property (p_receive_pin) else $error("receive mode not using pin clock");

   property p_sleep_stops;
      @(posedge i_clk) disable iff (!i_rstn)
         sleep [*2] |-> !o_system_clock && !o_debug_monitor_clock && !o_external_dac_clock;
   endproperty
   a_sleep_stops: assert property (p_sleep_stops) else $error("clocks running in sleep");

   property p_sys_div2;
      @(posedge i_clk) disable iff (!i_rstn)
         (!sleep && system_clock_divider_sel == 3'h0) [*3] |-> o_system_clock != $past(o_system_clock);
   endproperty
   a_sys_div2: assert property (p_sys_div2) else $error("system clock not master over two");

   property p_multiply;
      @(posedge i_clk) disable iff (!i_rstn) o_pll_ctrl.multiply == 4'h8;
   endproperty
   a_multiply: assert property (p_multiply) else $error("multiplier not eight");

   property p_gate_holds;
      @(posedge i_clk) disable iff (!i_rstn)
         (gate_enable && !i_bitclk_demand) [*2] |-> !bitclk_gen;
   endproperty
   a_gate_holds: assert property (p_gate_holds) else $error("gated bit clock ran without demand");

endmodule : decoder_clock_irq_host

`default_nettype wire

// File: dv/bitclk_source.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far-side serial bit clock source
// ==========================================================
module bitclk_source #(
   parameter int HALF = 4
) (
   // Clock and control
   input wire logic i_clk,
   input wire logic i_run,
   // Serial bit clock
   output logic o_bclk = 1'b0
);
   int cnt = 0;

   // Parked low outside frames so a stale level never looks like a clock
   always @(posedge i_clk) begin
      if (!i_run) begin
         cnt <= 0;
         o_bclk <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         o_bclk <= ~o_bclk;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : bitclk_source

`default_nettype wire

// File: dv/decoder_clock_irq_host_test.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench top
// ==========================================================
module decoder_clock_irq_host_test;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   decoder_clock_pkg::reg_req_t rq = '0;
   decoder_clock_pkg::pll_ctrl_t pll;
   logic [31:0] rdat;
   logic [7:0] ev = 8'h00;
   logic [7:0] cond = 8'h00;
   logic irq_n, rfck, sysck, spck, spen, dbgck, dacck, bpin, boe, bback, bsrc;
   logic brun = 1'b0;
   logic dem = 1'b1;
   logic pend = 1'b0;
   logic [31:0] seed = 32'h0000_cbb9;
   logic [31:0] exp_q[$];
   logic [11:0] adr[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h020, 12'h024};
   logic [7:0] msk[8] = '{8'h01, 8'h0F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF};
   int n[6];
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [7:0] d;

   always #50 i_clk = ~i_clk;

   decoder_clock_irq_host dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg(rq), .o_reg_rdata(rdat),
      .i_latched_events(ev), .i_passthrough_conditions(cond), .o_irq_n(irq_n), .o_pll_ctrl(pll),
      .o_rf_sample_clock(rfck), .o_system_clock(sysck), .o_spdif_clock(spck), .o_spdif_enable(spen),
      .o_debug_monitor_clock(dbgck), .o_external_dac_clock(dacck), .i_bitclk_demand(dem),
      .i_bitclk_pin(bsrc), .o_bitclk_pin(bpin), .o_bitclk_pin_oe(boe), .o_backend_bitclk(bback));

   bitclk_source #(.HALF(4)) partner (.i_clk(i_clk), .i_run(brun), .o_bclk(bsrc));

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // One access, request held across the taking edge
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge i_clk);
      rq <= '{1'b1, w, a, v};
      @(posedge i_clk);
      rq <= '0;
   endtask : acc

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      acc(1'b0, a, 8'h00);
   endtask : rd

   // Count rising edges of every generated clock except the RF sample clock over 96 cycles
   task automatic meas();
      logic [5:0] p;
      logic [5:0] c;
      n = '{0, 0, 0, 0, 0, 0};
      repeat (40) @(posedge i_clk);
      p = {bback, bpin, dacck, dbgck, spck, sysck};
      repeat (96) begin
         @(posedge i_clk);
         c = {bback, bpin, dacck, dbgck, spck, sysck};
         for (int i = 0; i < 6; i++) n[i] += int'(c[i] & ~p[i]);
         p = c;
      end
   endtask : meas

   task automatic pulse(input logic [7:0] v);
      @(posedge i_clk);
      ev <= v;
      @(posedge i_clk);
      ev <= 8'h00;
      repeat (3) @(posedge i_clk);
   endtask : pulse

   // Read data against the oldest note; hang guard
   always @(posedge i_clk) begin
      if (pend) chk("rdata", exp_q.pop_front(), rdat);
      pend <= rq.sel && !rq.write;
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      chk("irq_n", 1, irq_n);
      chk("pll", {4'h8, 1'b0}, pll);
      for (int i = 0; i < 8; i++) begin
         d = 8'(xs()) & msk[i];
         acc(1'b1, adr[i], d);
         rd(adr[i], d);
         if (i == 0) chk("halve", d[0], pll.prediv_two);
      end
      acc(1'b1, 12'h100, 8'hA5);
      rd(12'h100, 8'h00);
      acc(1'b1, 12'h018, 8'hFF);
      rd(12'h018, 8'h00);
      $display("test registers done");
      acc(1'b1, 12'h004, 8'h00);
      acc(1'b1, 12'h010, 8'h00);
      acc(1'b1, 12'h024, 8'h00);
      acc(1'b1, 12'h020, 8'h01);
      pulse(8'h02);
      chk("irq_n", 1, irq_n);
      pulse(8'h01);
      chk("irq_n", 0, irq_n);
      rd(12'h018, 8'h03);
      rd(12'h018, 8'h00);
      repeat (3) @(posedge i_clk);
      chk("irq_n", 1, irq_n);
      d = 8'(xs()) | 8'h01;
      cond <= d;
      repeat (2) @(posedge i_clk);
      rd(12'h01C, d);
      acc(1'b1, 12'h024, 8'h01);
      repeat (3) @(posedge i_clk);
      chk("irq_n", 0, irq_n);
      cond <= 8'h00;
      repeat (3) @(posedge i_clk);
      chk("irq_n", 1, irq_n);
      $display("test interrupts done");
      acc(1'b1, 12'h008, 8'h01);
      acc(1'b1, 12'h014, 8'h31);
      for (int s = 0; s < 6; s++) begin
         acc(1'b1, 12'h004, s[7:0]);
         meas();
         chk("sysclk", 96 >> ((s < 5) ? s + 1 : 5), n[0]);
      end
      chk("spdif", 0, n[1]);
      chk("spdif_en", 0, spen);
      chk("debug", 24, n[2]);
      chk("dac", 12, n[3]);
      chk("bitpin", 24, n[4]);
      chk("backend", 24, n[5]);
      #1 chk("rfclk", i_clk, rfck);
      acc(1'b1, 12'h008, 8'h81);
      dem <= 1'b0;
      meas();
      chk("gated", 0, n[4]);
      dem <= 1'b1;
      meas();
      chk("ungated", 24, n[4]);
      acc(1'b1, 12'h004, 8'h08);
      meas();
      chk("sleep_sys", 0, n[0]);
      chk("sleep_dbg", 0, n[2]);
      $display("test clocks done");
      acc(1'b1, 12'h004, 8'h00);
      acc(1'b1, 12'h00C, 8'h0B);
      acc(1'b1, 12'h010, 8'h03);
      brun <= 1'b1;
      meas();
      chk("spdif_en", 1, spen);
      chk("spdif", 4, n[1]);
      chk("backend", 12, n[5]);
      chk("bitpin_rx", 0, n[4]);
      chk("bit_oe", 0, boe);
      $display("test slave mode done");
      tally_and_finish();
   end
endmodule : decoder_clock_irq_host_test

`default_nettype wire
